// ===== logic/udq_pkg.sv
// constants, register map and state layout of the up/down and quadrature count logic
package udq_pkg;

   // timing
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned COINC_NS      = 20;
   localparam int unsigned COINC_CYC_RAW = COINC_NS / CLK_PERIOD_NS;
   localparam int unsigned COINC_CYC     = (COINC_CYC_RAW < 1) ? 1 : COINC_CYC_RAW;
   localparam int unsigned TMR_W         = 4;
   localparam logic [3:0]  TMR_LOAD      = TMR_W'(COINC_CYC);
   localparam logic [3:0]  TMR_ZERO      = 4'h0;
   localparam logic [3:0]  TMR_ONE       = 4'h1;

   // register bus
   localparam int unsigned ADDR_W      = 4;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned STRB_W      = 4;
   localparam logic [3:0]  OFF_CTRL    = 4'h0;
   localparam logic [3:0]  OFF_COUNT   = 4'h4;
   localparam logic [3:0]  OFF_STATUS  = 4'h8;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // control fields
   localparam int unsigned MODE_W        = 3;
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_LOCK_BIT = 4;
   localparam int unsigned CTRL_FLIP_BIT = 5;
   localparam int unsigned CTRL_STRB     = 0;

   // status fields
   localparam int unsigned STAT_INVALID_BIT = 0;
   localparam int unsigned STAT_DIR_BIT     = 1;
   localparam int unsigned STAT_STRB        = 0;

   // counting modes
   localparam logic [2:0] MODE_UPDOWN                = 3'h0;
   localparam logic [2:0] MODE_SINGLE_RES_QUADRATURE = 3'h1;
   localparam logic [2:0] MODE_DOUBLE_RES_QUADRATURE = 3'h2;
   localparam logic [2:0] MODE_QUAD_RES_QUADRATURE   = 3'h3;

   localparam logic [31:0] COUNT_ONE = 32'h1;

   typedef struct packed {
      logic [2:0]  mode;
      logic        lock;
      logic        flip;
      logic [31:0] count;
      logic        invalid;
      logic        dir_up;
      logic        a_meta;
      logic        a_sync;
      logic        a_prev;
      logic        b_meta;
      logic        b_sync;
      logic        b_prev;
      logic        pend_a;
      logic        pend_b;
      logic [3:0]  tmr;
      logic        aw_full;
      logic [3:0]  aw_addr;
      logic        w_full;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } udq_state_s;

   localparam udq_state_s ST_RST = '0;

endpackage : udq_pkg

// ===== logic/udq_count.sv
// up/down pulse and quadrature edge-to-count logic of one counter channel, AXI4-Lite registers
//
// What this block does
// - with both direction bits clear in up/down mode a primary rising edge adds one.
// - with both direction bits clear in up/down mode a secondary rising edge subtracts one.
// - in up/down mode with lock set and flip clear every rising edge adds one.
// - in up/down mode with only flip set the secondary adds one and the primary subtracts one.
// - in up/down mode with lock and flip set every rising edge subtracts one.
// - in up/down mode rising edges on both inputs together or nearly so leave the count alone.
// - in single resolution quadrature the phase relation gives direction, primary leading is up.
// - in single resolution, secondary low, primary rise counts up and primary fall counts down.
// - in single resolution, secondary high, primary rising edges are ignored.
// - in any quadrature mode both inputs changing together is invalid and makes no step.
// - double resolution keeps the single resolution directions with twice the steps.
// - quadruple resolution keeps the single resolution directions with four times the steps.
// - with lock set the inputs no longer steer direction and flip alone chooses it.
`timescale 1ns/1ns
module udq_count
   import udq_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   input  wire logic        pri_in,
   input  wire logic        sec_in,
   input  wire logic [3:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_awvalid_in,
   output      logic        s_axi_awready_out,
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   input  wire logic        s_axi_wvalid_in,
   output      logic        s_axi_wready_out,
   output      logic [1:0]  s_axi_bresp_out,
   output      logic        s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   input  wire logic [3:0]  s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   output      logic        s_axi_arready_out,
   output      logic [31:0] s_axi_rdata_out,
   output      logic [1:0]  s_axi_rresp_out,
   output      logic        s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   output      logic [31:0] count_out,
   output      logic        dir_up_out,
   output      logic        invalid_out
);

   udq_state_s  st;
   udq_state_s  next_st;
   logic        rise_a;
   logic        fall_a;
   logic        chg_a;
   logic        rise_b;
   logic        chg_b;
   logic        step;
   logic        raw_up;
   logic        eff_up;
   logic        bad;
   logic        wr_go;
   logic        ctrl_wr;
   logic        count_wr;
   logic        stat_wr;
   logic        apply_up;
   logic        apply_dn;
   logic [31:0] byte_mask;
   logic [31:0] rd_word;

   // edges only from the second sync stage and its delayed copy
   assign rise_a = st.a_sync & ~st.a_prev;
   assign fall_a = ~st.a_sync & st.a_prev;
   assign chg_a  = st.a_sync ^ st.a_prev;
   assign rise_b = st.b_sync & ~st.b_prev;
   assign chg_b  = st.b_sync ^ st.b_prev;

   genvar g;
   generate
      for (g = 0; g < STRB_W; g = g + 1) begin : g_mask
         assign byte_mask[8*g +: 8] = {8{st.w_strb[g]}};
      end
   endgenerate

   always_comb begin
      next_st  = st;
      step     = 1'b0;
      raw_up   = 1'b0;
      bad      = 1'b0;
      ctrl_wr  = 1'b0;
      count_wr = 1'b0;
      stat_wr  = 1'b0;
      rd_word  = '0;

      next_st.a_meta = pri_in;
      next_st.a_sync = st.a_meta;
      next_st.a_prev = st.a_sync;
      next_st.b_meta = sec_in;
      next_st.b_sync = st.b_meta;
      next_st.b_prev = st.b_sync;

      // edge decoding per mode
      case (st.mode)
         MODE_UPDOWN: begin
            // each edge waits out the coincidence window so a near pair cancels
            if (rise_a && rise_b) begin
               next_st.pend_a = 1'b0;
               next_st.pend_b = 1'b0;
            end else if ((st.pend_a && rise_b) || (st.pend_b && rise_a)) begin
               next_st.pend_a = 1'b0;
               next_st.pend_b = 1'b0;
            end else if (st.pend_a || st.pend_b) begin
               if (st.tmr == TMR_ZERO) begin
                  step           = 1'b1;
                  raw_up         = st.pend_a;
                  next_st.pend_a = 1'b0;
                  next_st.pend_b = 1'b0;
               end else begin
                  next_st.tmr = st.tmr - TMR_ONE;
               end
            end else if (rise_a || rise_b) begin
               next_st.pend_a = rise_a;
               next_st.pend_b = rise_b;
               next_st.tmr    = TMR_LOAD;
            end
         end
         MODE_SINGLE_RES_QUADRATURE: begin
            next_st.pend_a = 1'b0;
            next_st.pend_b = 1'b0;
            if (chg_a && chg_b) begin
               bad = 1'b1;
            end else if (chg_a && !st.b_sync) begin
               // rise counts up, fall counts down; with b high nothing counts
               step   = 1'b1;
               raw_up = rise_a;
            end
         end
         MODE_DOUBLE_RES_QUADRATURE: begin
            next_st.pend_a = 1'b0;
            next_st.pend_b = 1'b0;
            if (chg_a && chg_b) begin
               bad = 1'b1;
            end else if (chg_a) begin
               step   = 1'b1;
               raw_up = st.a_sync ^ st.b_sync;
            end
         end
         MODE_QUAD_RES_QUADRATURE: begin
            next_st.pend_a = 1'b0;
            next_st.pend_b = 1'b0;
            if (chg_a && chg_b) begin
               bad = 1'b1;
            end else if (chg_a) begin
               step   = 1'b1;
               raw_up = st.a_sync ^ st.b_sync;
            end else if (chg_b) begin
               step   = 1'b1;
               raw_up = ~(st.a_sync ^ st.b_sync);
            end
         end
         default: begin
            // unsupported codes count nothing; mode legality is software's job
            next_st.pend_a = 1'b0;
            next_st.pend_b = 1'b0;
         end
      endcase

      // lock ignores the inputs, flip then is the direction
      eff_up = st.lock ? ~st.flip : (raw_up ^ st.flip);

      // write channel
      wr_go = st.aw_full && st.w_full && !st.bvalid;
      if (s_axi_awvalid_in && st.awready) begin
         next_st.aw_full = 1'b1;
         next_st.aw_addr = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && st.wready) begin
         next_st.w_full = 1'b1;
         next_st.w_data = s_axi_wdata_in;
         next_st.w_strb = s_axi_wstrb_in;
      end
      if (st.bvalid && s_axi_bready_in) begin
         next_st.bvalid = 1'b0;
      end
      if (wr_go) begin
         next_st.aw_full = 1'b0;
         next_st.w_full  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = RESP_OKAY;
         case (st.aw_addr)
            OFF_CTRL:   ctrl_wr = 1'b1;
            OFF_COUNT:  count_wr = 1'b1;
            OFF_STATUS: stat_wr = 1'b1;
            default:    next_st.bresp = RESP_SLVERR;
         endcase
      end
      next_st.awready = !next_st.aw_full && !next_st.bvalid;
      next_st.wready  = !next_st.w_full && !next_st.bvalid;

      if (ctrl_wr && st.w_strb[CTRL_STRB]) begin
         next_st.mode = st.w_data[CTRL_MODE_LSB +: MODE_W];
         next_st.lock = st.w_data[CTRL_LOCK_BIT];
         next_st.flip = st.w_data[CTRL_FLIP_BIT];
      end

      // a software load beats an edge step in the same cycle
      if (count_wr) begin
         next_st.count = (st.count & ~byte_mask) | (st.w_data & byte_mask);
      end else if (step) begin
         next_st.count  = eff_up ? st.count + COUNT_ONE : st.count - COUNT_ONE;
         next_st.dir_up = eff_up;
      end

      // set beats the write-one clear
      next_st.invalid = bad | (st.invalid &
                        !(stat_wr && st.w_strb[STAT_STRB] && st.w_data[STAT_INVALID_BIT]));

      // read channel
      case (s_axi_araddr_in)
         OFF_CTRL: begin
            rd_word[CTRL_MODE_LSB +: MODE_W] = st.mode;
            rd_word[CTRL_LOCK_BIT]           = st.lock;
            rd_word[CTRL_FLIP_BIT]           = st.flip;
         end
         OFF_COUNT: rd_word = st.count;
         OFF_STATUS: begin
            rd_word[STAT_INVALID_BIT] = st.invalid;
            rd_word[STAT_DIR_BIT]     = st.dir_up;
         end
         default: rd_word = '0;
      endcase
      if (st.rvalid && s_axi_rready_in) begin
         next_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid_in && st.arready) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = rd_word;
         next_st.rresp  = (s_axi_araddr_in == OFF_CTRL || s_axi_araddr_in == OFF_COUNT ||
                           s_axi_araddr_in == OFF_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end
      next_st.arready = !next_st.rvalid;
   end

   assign apply_up = step && eff_up && !count_wr;
   assign apply_dn = step && !eff_up && !count_wr;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st <= ST_RST;
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_awready_out = st.awready;
   assign s_axi_wready_out  = st.wready;
   assign s_axi_bresp_out   = st.bresp;
   assign s_axi_bvalid_out  = st.bvalid;
   assign s_axi_arready_out = st.arready;
   assign s_axi_rdata_out   = st.rdata;
   assign s_axi_rresp_out   = st.rresp;
   assign s_axi_rvalid_out  = st.rvalid;
   assign count_out         = st.count;
   assign dir_up_out        = st.dir_up;
   assign invalid_out       = st.invalid;

   // checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);

   logic updown_plain;
   logic quad_plain;
   assign updown_plain = (st.mode == MODE_UPDOWN) && !st.lock && !st.flip;
   assign quad_plain   = !st.lock && !st.flip;

   sequence s_a_waiting;
      st.pend_a && !st.pend_b && (st.mode == MODE_UPDOWN);
   endsequence

   sequence s_b_arrives;
      rise_b && !rise_a;
   endsequence

   a_step_up_count: assert property (apply_up |=> st.count == $past(st.count) + COUNT_ONE)
      else $error("count did not rise by one");

   a_step_dn_count: assert property (apply_dn |=> st.count == $past(st.count) - COUNT_ONE)
      else $error("count did not fall by one");

   a_updown_pri_up: assert property ((updown_plain && rise_a && !rise_b && !st.pend_a &&
                                      !st.pend_b && !count_wr) ##1
                                     (!rise_b && updown_plain && !count_wr) [*6]
                                     |=> st.count == $past(st.count, 7) + COUNT_ONE)
      else $error("primary edge did not add one");

   a_lock_all_up: assert property ((st.mode == MODE_UPDOWN) && st.lock && !st.flip && step &&
                                   !count_wr |=> st.count == $past(st.count) + COUNT_ONE)
      else $error("locked up/down did not count up");

   a_flip_swaps: assert property ((st.mode == MODE_UPDOWN) && !st.lock && st.flip && step &&
                                  !count_wr |=> st.count == ($past(st.pend_a) ?
                                  $past(st.count) - COUNT_ONE : $past(st.count) + COUNT_ONE))
      else $error("flip did not swap directions");

   a_lock_flip_dn: assert property ((st.mode == MODE_UPDOWN) && st.lock && st.flip && step &&
                                    !count_wr |=> st.count == $past(st.count) - COUNT_ONE)
      else $error("locked and flipped did not count down");

   a_near_cancel: assert property (s_a_waiting ##0 s_b_arrives ##0 !count_wr
                                   |=> !st.pend_a && !st.pend_b && $stable(st.count))
      else $error("near simultaneous edges changed the count");

   a_both_cancel: assert property ((st.mode == MODE_UPDOWN) && rise_a && rise_b
                                   |-> !step ##1 !st.pend_a && !st.pend_b)
      else $error("simultaneous edges started a step");

   a_single_rise_up: assert property ((st.mode == MODE_SINGLE_RES_QUADRATURE) && quad_plain &&
                                      rise_a && !chg_b && !st.b_sync |-> step && eff_up)
      else $error("single resolution rise did not count up");

   a_single_fall_dn: assert property ((st.mode == MODE_SINGLE_RES_QUADRATURE) && quad_plain &&
                                      fall_a && !chg_b && !st.b_sync |-> step && !eff_up)
      else $error("single resolution fall did not count down");

   a_single_b_high: assert property ((st.mode == MODE_SINGLE_RES_QUADRATURE) && rise_a &&
                                     st.b_sync && !chg_b |-> !step)
      else $error("rise with secondary high was counted");

   a_quad_invalid: assert property ((st.mode != MODE_UPDOWN) &&
                                    (st.mode <= MODE_QUAD_RES_QUADRATURE) &&
                                    chg_a && chg_b |-> !step ##1 st.invalid)
      else $error("double transition not flagged invalid");

   a_double_fall: assert property ((st.mode == MODE_DOUBLE_RES_QUADRATURE) && quad_plain &&
                                   fall_a && !chg_b && st.b_sync |-> step && eff_up)
      else $error("double resolution fall with secondary high not up");

   a_quadres_b_edge: assert property ((st.mode == MODE_QUAD_RES_QUADRATURE) && quad_plain &&
                                      rise_b && !chg_a && st.a_sync |-> step && eff_up)
      else $error("quadruple resolution secondary rise not up");

   a_lock_direction: assert property (st.lock && step && !count_wr
                                      |=> st.dir_up == !$past(st.flip))
      else $error("locked direction not set by flip");

   a_bvalid_holds: assert property (st.bvalid && !s_axi_bready_in |=> st.bvalid)
      else $error("write response dropped early");

endmodule : udq_count

// ===== test/udq_src.sv
// far-side model: pulse sources or a quadrature encoder on the two count inputs
`timescale 1ns/1ns
module udq_src (
   input  wire logic clk_in,
   output      logic pri_out,
   output      logic sec_out
);
   initial begin
      pri_out = 1'b0;
      sec_out = 1'b0;
   end
   // push-pull lines; levels move just after an edge and hold, never under two cycles
   task automatic set_ab(input logic a, input logic b, input int hold);
      @(posedge clk_in);
      pri_out <= a;
      sec_out <= b;
      repeat (hold) @(posedge clk_in);
   endtask : set_ab
endmodule : udq_src

// ===== test/tb_udq_count.sv
// self-checking bench of the up/down and quadrature count logic
`timescale 1ns/1ns
module tb_udq_count
   import udq_pkg::*;
;
   logic clk_in, resetn_in = 1'b0;
   logic pri, sec, awready, wready, bvalid, arready, rvalid, dir_up, inval;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, cnt, rd;
   logic [1:0]  bresp, rresp;
   logic [2:0]  mode;
   logic        lk, fl, a_lv = 1'b0, b_lv = 1'b0;
   int err_total = 0, checked = 0, cyc = 0, seed = 66536, exp, last_d;

   udq_src udq_src_inst (.clk_in(clk_in), .pri_out(pri), .sec_out(sec));
   udq_count udq_count_inst (.clk_in(clk_in), .resetn_in(resetn_in), .pri_in(pri),
      .sec_in(sec), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
      .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
      .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
      .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
      .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      .count_out(cnt), .dir_up_out(dir_up), .invalid_out(inval));

   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim

   // cut a hang short well past the expected run length
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, want);
      end
   endtask : chk

   task automatic axi_wr(input logic [3:0] ad, input logic [31:0] d, input logic [3:0] st,
                         input logic [1:0] rsp);
      logic aw_t, w_t, b_t;
      @(posedge clk_in);
      awaddr  <= ad;
      wdata   <= d;
      wstrb   <= st;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      aw_t = 1'b0;
      w_t = 1'b0;
      b_t = 1'b0;
      while (!b_t) begin
         @(posedge clk_in);
         if (!aw_t && awready) begin
            awvalid <= 1'b0;
            aw_t = 1'b1;
         end
         if (!w_t && wready) begin
            wvalid <= 1'b0;
            w_t = 1'b1;
         end
         if (bvalid) begin
            bready <= 1'b0;
            b_t = 1'b1;
            chk(32'(bresp), 32'(rsp));
         end
      end
      #1;
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] ad, input logic [1:0] rsp, output logic [31:0] d);
      logic ar_t, r_t;
      @(posedge clk_in);
      araddr  <= ad;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      ar_t = 1'b0;
      r_t = 1'b0;
      while (!r_t) begin
         @(posedge clk_in);
         if (!ar_t && arready) begin
            arvalid <= 1'b0;
            ar_t = 1'b1;
         end
         if (rvalid) begin
            rready <= 1'b0;
            r_t = 1'b1;
            d = rdata;
            chk(32'(rresp), 32'(rsp));
         end
      end
   endtask : axi_rd

   // reference step of one input edge; oth is the level of the other input
   function automatic int step_d(input logic is_a, input logic rise, input logic oth);
      int r;
      r = 0;
      case (mode)
         MODE_UPDOWN: if (rise) r = is_a ? 1 : -1;
         MODE_SINGLE_RES_QUADRATURE: if (is_a && !oth) r = rise ? 1 : -1;
         MODE_DOUBLE_RES_QUADRATURE: if (is_a) r = (rise ^ oth) ? 1 : -1;
         MODE_QUAD_RES_QUADRATURE:
            r = (is_a ? (rise ^ oth) : (rise == oth)) ? 1 : -1;
         default: r = 0;
      endcase
      if (r != 0 && lk)
         r = fl ? -1 : 1;
      else if (fl)
         r = -r;
      return r;
   endfunction : step_d

   // hold of 12 lets the coincidence window and the sync stages settle before checking
   task automatic move(input logic a, input logic b, input int hold, input int adj);
      logic ca, cb;
      ca = (a != a_lv);
      cb = (b != b_lv);
      last_d = 0;
      if (ca && !cb)
         last_d = step_d(1'b1, a, b_lv);
      else if (cb && !ca)
         last_d = step_d(1'b0, b, a_lv);
      // the cancelling edge makes no step of its own
      if (adj != 0)
         last_d = 0;
      exp = exp + last_d + adj;
      a_lv = a;
      b_lv = b;
      udq_src_inst.set_ab(a, b, hold);
      if (hold >= 12) begin
         #1;
         chk(cnt, 32'(exp));
         if (last_d != 0 && adj == 0)
            chk(32'(dir_up), 32'(last_d > 0));
         if (ca && cb && mode != MODE_UPDOWN) begin
            chk(32'(inval), 32'h1);
            axi_wr(OFF_STATUS, 32'h1, 4'hf, RESP_OKAY);
            chk(32'(inval), 32'h0);
         end
      end
   endtask : move

   initial begin
      repeat (8) @(posedge clk_in);
      resetn_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      #1;
      chk(cnt, 32'h0);
      axi_rd(OFF_CTRL, RESP_OKAY, rd);
      chk(rd, 32'h0);
      axi_rd(OFF_STATUS, RESP_OKAY, rd);
      chk(rd, 32'h0);
      axi_wr(4'hc, 32'hffffffff, 4'hf, RESP_SLVERR);
      axi_rd(4'hc, RESP_SLVERR, rd);
      chk(rd, 32'h0);
      axi_wr(OFF_COUNT, 32'h12345678, 4'hf, RESP_OKAY);
      axi_wr(OFF_COUNT, 32'haaaaaaaa, 4'h2, RESP_OKAY);
      axi_rd(OFF_COUNT, RESP_OKAY, rd);
      chk(rd, 32'h1234aa78);
      // one channel only, so every mode is a legal choice
      for (int m = 0; m < 4; m++) begin
         for (int c = 0; c < 4; c++) begin
            mode = 3'(m);
            lk = c[0];
            fl = c[1];
            rd = 32'(mode) | (32'(lk) << CTRL_LOCK_BIT) | (32'(fl) << CTRL_FLIP_BIT);
            axi_wr(OFF_CTRL, rd, 4'hf, RESP_OKAY);
            axi_rd(OFF_CTRL, RESP_OKAY, rd);
            chk(rd, 32'(mode) | (32'(lk) << CTRL_LOCK_BIT) | (32'(fl) << CTRL_FLIP_BIT));
            exp = $random(seed);
            axi_wr(OFF_COUNT, 32'(exp), 4'hf, RESP_OKAY);
            chk(cnt, 32'(exp));
            move(1'b1, 1'b0, 12, 0);
            move(1'b1, 1'b1, 12, 0);
            move(1'b0, 1'b1, 12, 0);
            move(1'b0, 1'b0, 12, 0);
            move(1'b0, 1'b1, 12, 0);
            move(1'b1, 1'b1, 12, 0);
            move(1'b1, 1'b0, 12, 0);
            move(1'b0, 1'b0, 12, 0);
            move(1'b1, 1'b1, 12, 0);
            move(1'b0, 1'b0, 12, 0);
            if (mode == MODE_UPDOWN) begin
               // second edge inside the window cancels the pending first one
               move(1'b1, 1'b0, 3, 0);
               move(1'b1, 1'b1, 12, -last_d);
               move(1'b0, 1'b0, 12, 0);
            end else begin
               // fast encoder walk, single-line changes three to six cycles apart
               repeat (24) begin
                  if ($random(seed) & 1)
                     move(~a_lv, b_lv, 2 + ($random(seed) & 3), 0);
                  else
                     move(a_lv, ~b_lv, 2 + ($random(seed) & 3), 0);
               end
               move(a_lv, b_lv, 12, 0);
               if (a_lv)
                  move(1'b0, b_lv, 12, 0);
               if (b_lv)
                  move(1'b0, 1'b0, 12, 0);
            end
            axi_rd(OFF_COUNT, RESP_OKAY, rd);
            chk(rd, 32'(exp));
         end
      end
      // a code outside the four modes counts nothing
      mode = 3'h4;
      lk = 1'b0;
      fl = 1'b0;
      axi_wr(OFF_CTRL, 32'(mode), 4'hf, RESP_OKAY);
      move(1'b1, 1'b0, 12, 0);
      move(1'b1, 1'b1, 12, 0);
      move(1'b0, 1'b1, 12, 0);
      move(1'b0, 1'b0, 12, 0);
      axi_rd(OFF_COUNT, RESP_OKAY, rd);
      chk(rd, 32'(exp));
      end_sim();
   end
endmodule : tb_udq_count
